// file: pprt_pkg.sv
/*
 * Constants and types of the packet port router.
 * Assumes one core clock and importers of pprt_pkg::*.
 */
package pprt_pkg;

  localparam int          NPORT            = 3;
  localparam int          DATA_W           = 64;
  localparam int          USER_W           = 32;

  localparam logic [23:0] OFF_WIN_BASE     = 24'h00005c;
  localparam logic [23:0] OFF_BASE_ID      = 24'h000060;
  localparam logic [23:0] OFF_RESP_TIMEOUT = 24'h000124;
  localparam logic [23:0] OFF_PORT_GEN_CTL = 24'h00013c;
  localparam logic [23:0] OFF_STATUS       = 24'h000200;

  localparam int          SMALL_ID_LSB     = 16;
  localparam int          LARGE_ID_LSB     = 0;
  localparam int          WIN_LSB          = 21;
  localparam int          WIN_W            = 10;
  localparam int          ADDR_WIN_LSB     = 24;
  localparam int          SRC_ID_LSB       = 16;
  localparam int          HOST_GRANT_BIT   = 30;
  localparam int          TIMEOUT_LSB      = 8;

  localparam logic [31:0] BASE_ID_RST      = 32'h0000_0000;
  localparam logic [31:0] WIN_BASE_RST     = 32'h7fe0_0000;
  localparam logic [31:0] TIMEOUT_RST      = 32'hffff_ff00;
  localparam logic [5:0]  ORDER_RST        = 6'h24;

  localparam logic [1:0]  ID_SIZE_SMALL    = 2'h0;
  localparam logic [1:0]  ID_SIZE_LARGE    = 2'h1;
  localparam logic [2:0]  INIT_PORT_MASK   = 3'h3;
  localparam logic [7:0]  SIZE_WORD_M1     = 8'h03;

  typedef struct packed {
    logic [DATA_W-1:0] tdata;
    logic              tlast;
    logic [USER_W-1:0] tuser;
  } pprt_beat_t;

  typedef enum logic {
    PPRT_IDLE = 1'b0,
    PPRT_XFER = 1'b1
  } pprt_fsm_t;

endpackage : pprt_pkg

// file: pprt_beat_if.sv
/*
 * Beat carrier from the port selector into the two-entry buffer.
 * Assumes the source pushes only while ready is high.
 */
`timescale 1ns/1ps
interface pprt_beat_if;
  import pprt_pkg::*;
  pprt_beat_t beat;
  logic       valid;
  logic       ready;
  logic       space_nxt;
  modport src (output beat, output valid, input ready, input space_nxt);
  modport snk (input beat, input valid, output ready, output space_nxt);
endinterface : pprt_beat_if

// file: pprt_skid.sv
/*
 * Two-entry buffer on the transmit path; outputs are registered except space_nxt.
 * Assumes the receiver may stall at any time.
 */
`timescale 1ns/1ps
module pprt_skid (
  input  wire logic                clock,     // Core clock
  input  wire logic                rst_n,     // Async reset, active low
  pprt_beat_if.snk                 in_if,     // Filling side
  output pprt_pkg::pprt_beat_t     out_beat,  // Head entry
  output logic                     out_valid, // Head valid
  input  wire logic                out_ready  // Receiver accepts
);
  import pprt_pkg::*;

  typedef struct packed {
    logic       h_v;
    logic       t_v;
    pprt_beat_t h;
    pprt_beat_t t;
  } pprt_skid_t;

  pprt_skid_t s_r;
  pprt_skid_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (out_ready && s_r.h_v) begin
      s_nxt.h_v = s_r.t_v;
      s_nxt.h   = s_r.t;
      s_nxt.t_v = 1'b0;
    end
    if (in_if.valid && !s_r.t_v) begin
      if (!s_nxt.h_v) begin
        s_nxt.h_v = 1'b1;
        s_nxt.h   = in_if.beat;
      end else begin
        s_nxt.t_v = 1'b1;
        s_nxt.t   = in_if.beat;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign in_if.ready     = !s_r.t_v;
  // Lets the selector register ready a cycle ahead
  assign in_if.space_nxt = !s_nxt.t_v;
  assign out_beat        = s_r.h;
  assign out_valid       = s_r.h_v;
endmodule : pprt_skid

// file: pprt_lru_arb.sv
/*
 * Least-recently-served arbiter over the transmit ports.
 * Assumes take is pulsed only while gnt_vld is high.
 */
`timescale 1ns/1ps
module pprt_lru_arb (
  input  wire logic                    clock,   // Core clock
  input  wire logic                    rst_n,   // Async reset, active low
  input  wire logic [pprt_pkg::NPORT-1:0] req,  // Eligible requests
  input  wire logic                    take,    // Commit current grant
  output logic [1:0]                   gnt_idx, // Granted port
  output logic                         gnt_vld  // Any grant
);
  import pprt_pkg::*;

  typedef struct packed {
    logic [NPORT-1:0][1:0] order;
  } pprt_arb_t;

  pprt_arb_t a_r;
  pprt_arb_t a_nxt;
  logic [1:0] pos;

  always_comb begin
    a_nxt   = a_r;
    pos     = 2'h0;
    gnt_vld = 1'b0;
    // Front of the order is the port idle the longest
    for (int k = 0; k < NPORT; k++) begin
      if (!gnt_vld && req[a_r.order[k]]) begin
        gnt_vld = 1'b1;
        pos     = 2'(k);
      end
    end
    gnt_idx = a_r.order[pos];
    if (take && gnt_vld) begin
      for (int k = 0; k < NPORT - 1; k++) begin
        if (k >= int'(pos)) begin
          a_nxt.order[k] = a_r.order[k+1];
        end
      end
      a_nxt.order[NPORT-1] = a_r.order[pos];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      a_r <= ORDER_RST;
    end else begin
      a_r <= a_nxt;
    end
  end
endmodule : pprt_lru_arb

// file: pprt_router.sv
/*
 * Top of the packet port router: transmit port arbitration into one stream,
 * ID handling, configuration registers and receive-side window steering.
 * Assumes user ports and the transmit buffer share the core clock.
 */
`timescale 1ns/1ps
module pprt_router #(
  parameter bit LARGE_SYSTEM   = 1'b0,  // 16-bit identifiers when set
  parameter bit WINDOW_EN      = 1'b1,  // Window base checking built
  parameter bit MAINT_PORT_EN  = 1'b1,  // Maintenance port built
  parameter bit HOST_GRANT_RST = 1'b0   // Reset value of host-grant enable
) (
  input  wire logic                                        clock,          // Core clock
  input  wire logic                                        rst_n,          // Async reset, active low
  input  wire logic [pprt_pkg::NPORT-1:0]                  tx_tvalid,      // Port beat valid
  output logic      [pprt_pkg::NPORT-1:0]                  tx_tready,      // Port beat taken
  input  wire logic [pprt_pkg::NPORT-1:0][pprt_pkg::DATA_W-1:0] tx_tdata,  // Port data
  input  wire logic [pprt_pkg::NPORT-1:0]                  tx_tlast,       // Port last beat
  input  wire logic [pprt_pkg::NPORT-1:0][pprt_pkg::USER_W-1:0] tx_tuser,  // Port src/dst IDs
  input  wire logic                                        initiator_block,// Requests barred
  output logic                                             out_tvalid,     // Stream valid
  input  wire logic                                        out_tready,     // Buffer accepts
  output logic      [pprt_pkg::DATA_W-1:0]                 out_tdata,      // Stream data
  output logic                                             out_tlast,      // Stream last
  output logic      [pprt_pkg::USER_W-1:0]                 out_tuser,      // Stream IDs
  output logic      [15:0]                                 out_src_id,     // Source ID of beat
  output logic      [1:0]                                  id_size_code,   // Size code
  output logic      [15:0]                                 own_id,         // Own device ID
  output logic      [23:0]                                 port_timeout,   // Response time-out
  output logic                                             host_grant_en,  // Host-grant enable
  input  wire logic                                        cfg_wr,         // Config write
  input  wire logic                                        cfg_rd,         // Config read
  input  wire logic [23:0]                                 cfg_addr,       // Config offset
  input  wire logic [31:0]                                 cfg_wdata,      // Config write data
  output logic      [31:0]                                 cfg_rdata,      // Config read data
  output logic                                             cfg_rvalid,     // Read data valid
  input  wire logic                                        rx_valid,       // Request header valid
  input  wire logic                                        rx_is_maint,    // Maintenance class
  input  wire logic                                        rx_is_swrite,   // Streaming write
  input  wire logic                                        rx_is_read,     // Read request
  input  wire logic                                        rx_needs_resp,  // Write wants response
  input  wire logic [33:0]                                 rx_addr,        // Transaction address
  input  wire logic [7:0]                                  rx_size_m1,     // Size minus one
  input  wire logic [15:0]                                 rx_src_id,      // Request source ID
  input  wire logic [15:0]                                 rx_dst_id,      // Request dest ID
  input  wire logic [7:0]                                  rx_tid,         // Transaction ID
  input  wire logic [31:0]                                 rx_wdata,       // Write data word
  output logic                                             io_req,         // To normal I/O
  output logic                                             maint_req,      // To maintenance port
  output logic                                             maint_write,    // Maint write
  output logic      [23:0]                                 maint_addr,     // Maint offset
  output logic      [31:0]                                 maint_wdata,    // Maint data
  output logic                                             err_resp,       // Error response due
  output logic      [15:0]                                 resp_src_id,    // Response source ID
  output logic      [15:0]                                 resp_dst_id,    // Response dest ID
  output logic      [7:0]                                  resp_tid        // Response TID
);
  import pprt_pkg::*;

  typedef struct packed {
    pprt_fsm_t        fsm;
    logic [1:0]       sel;
    logic [NPORT-1:0] tready;
    logic [31:0]      base_id;
    logic [31:0]      win_base;
    logic [31:0]      timeout;
    logic             host_grant;
    logic [7:0]       drop_cnt;
    logic [31:0]      rdata;
    logic             rvalid;
    logic [15:0]      own_id;
    logic [1:0]       size_code;
    logic             io_req;
    logic             maint_req;
    logic             maint_write;
    logic [23:0]      maint_addr;
    logic [31:0]      maint_wdata;
    logic             err_resp;
    logic [15:0]      resp_src;
    logic [15:0]      resp_dst;
    logic [7:0]       resp_tid;
  } pprt_state_t;

  localparam pprt_state_t STATE_RST = '{
    fsm:         PPRT_IDLE,
    sel:         2'h0,
    tready:      '0,
    base_id:     BASE_ID_RST,
    win_base:    WIN_BASE_RST,
    timeout:     TIMEOUT_RST,
    host_grant:  HOST_GRANT_RST,
    drop_cnt:    8'h00,
    rdata:       32'h0000_0000,
    rvalid:      1'b0,
    own_id:      16'h0000,
    size_code:   LARGE_SYSTEM ? ID_SIZE_LARGE : ID_SIZE_SMALL,
    io_req:      1'b0,
    maint_req:   1'b0,
    maint_write: 1'b0,
    maint_addr:  24'h000000,
    maint_wdata: 32'h0000_0000,
    err_resp:    1'b0,
    resp_src:    16'h0000,
    resp_dst:    16'h0000,
    resp_tid:    8'h00
  };

  pprt_state_t s_r;
  pprt_state_t s_nxt;

  pprt_beat_if      bif ();
  pprt_beat_t       head;
  logic [NPORT-1:0] eligible;
  logic [1:0]       gnt_idx;
  logic             gnt_vld;
  logic             take;
  logic             beat_in;
  logic             win_hit;
  logic             to_maint;
  logic             size_ok;

  // Request ports drop out while the buffer bars initiators
  assign eligible = tx_tvalid & ~(INIT_PORT_MASK & {NPORT{initiator_block}});
  assign take     = (s_r.fsm == PPRT_IDLE) && gnt_vld;

  pprt_lru_arb u_arb (
    .clock   (clock),
    .rst_n   (rst_n),
    .req     (eligible),
    .take    (take),
    .gnt_idx (gnt_idx),
    .gnt_vld (gnt_vld)
  );

  // Ready registered against buffer space, so a beat always fits
  assign beat_in         = s_r.tready[s_r.sel] && tx_tvalid[s_r.sel];
  assign bif.valid       = beat_in;
  assign bif.beat        = {tx_tdata[s_r.sel], tx_tlast[s_r.sel], tx_tuser[s_r.sel]};

  pprt_skid u_skid (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_if     (bif),
    .out_beat  (head),
    .out_valid (out_tvalid),
    .out_ready (out_tready)
  );

  // Streaming writes and disabled window skip the compare
  assign win_hit  = WINDOW_EN && !rx_is_maint && !rx_is_swrite &&
                    (rx_addr[ADDR_WIN_LSB +: WIN_W] == s_r.win_base[WIN_LSB +: WIN_W]);
  assign to_maint = rx_is_maint || (win_hit && MAINT_PORT_EN);
  assign size_ok  = (rx_size_m1 == SIZE_WORD_M1);

  always_comb begin
    s_nxt = s_r;
    s_nxt.rvalid    = 1'b0;
    s_nxt.io_req    = 1'b0;
    s_nxt.maint_req = 1'b0;
    s_nxt.err_resp  = 1'b0;

    // Transmit: one packet at a time into the shared stream
    case (s_r.fsm)
      PPRT_IDLE: begin
        if (gnt_vld) begin
          s_nxt.fsm = PPRT_XFER;
          s_nxt.sel = gnt_idx;
        end
      end
      PPRT_XFER: begin
        // Packet ends on its own last beat; no mid-packet interleave
        if (beat_in && tx_tlast[s_r.sel]) begin
          s_nxt.fsm = PPRT_IDLE;
        end
      end
      default: begin
        s_nxt.fsm = PPRT_IDLE;
      end
    endcase
    s_nxt.tready = '0;
    if (s_nxt.fsm == PPRT_XFER && bif.space_nxt) begin
      s_nxt.tready[s_nxt.sel] = 1'b1;
    end

    // Configuration access
    if (cfg_wr) begin
      case (cfg_addr)
        OFF_BASE_ID:      s_nxt.base_id  = cfg_wdata;
        OFF_WIN_BASE:     s_nxt.win_base = cfg_wdata;
        OFF_RESP_TIMEOUT: s_nxt.timeout  = cfg_wdata;
        OFF_PORT_GEN_CTL: s_nxt.host_grant = cfg_wdata[HOST_GRANT_BIT];
        default: begin
        end
      endcase
    end
    if (cfg_rd) begin
      s_nxt.rvalid = 1'b1;
      case (cfg_addr)
        OFF_BASE_ID:      s_nxt.rdata = s_r.base_id;
        OFF_WIN_BASE:     s_nxt.rdata = s_r.win_base;
        OFF_RESP_TIMEOUT: s_nxt.rdata = s_r.timeout;
        OFF_PORT_GEN_CTL: s_nxt.rdata = 32'(s_r.host_grant) << HOST_GRANT_BIT;
        OFF_STATUS:       s_nxt.rdata = {21'h000000, s_r.fsm, s_r.sel, s_r.drop_cnt};
        default:          s_nxt.rdata = 32'h0000_0000;
      endcase
    end

    // Own ID follows the register, one cycle behind
    if (LARGE_SYSTEM) begin
      s_nxt.own_id = s_r.base_id[LARGE_ID_LSB +: 16];
    end else begin
      s_nxt.own_id = {8'h00, s_r.base_id[SMALL_ID_LSB +: 8]};
    end

    // Receive steering; one decision per header cycle
    if (rx_valid) begin
      // IDs from the request itself; register writes cannot alter them
      s_nxt.resp_src = rx_dst_id;
      s_nxt.resp_dst = rx_src_id;
      s_nxt.resp_tid = rx_tid;
      if (!to_maint) begin
        s_nxt.io_req = 1'b1;
      end else if (size_ok) begin
        s_nxt.maint_req   = 1'b1;
        s_nxt.maint_write = !rx_is_read;
        s_nxt.maint_addr  = rx_addr[23:0];
        s_nxt.maint_wdata = rx_wdata;
      end else begin
        s_nxt.err_resp = rx_is_read || rx_needs_resp;
        s_nxt.drop_cnt = s_r.drop_cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= STATE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tx_tready     = s_r.tready;
  assign out_tdata     = head.tdata;
  assign out_tlast     = head.tlast;
  assign out_tuser     = head.tuser;
  assign out_src_id    = head.tuser[SRC_ID_LSB +: 16];
  assign id_size_code  = s_r.size_code;
  assign own_id        = s_r.own_id;
  assign port_timeout  = s_r.timeout[TIMEOUT_LSB +: 24];
  assign host_grant_en = s_r.host_grant;
  assign cfg_rdata     = s_r.rdata;
  assign cfg_rvalid    = s_r.rvalid;
  assign io_req        = s_r.io_req;
  assign maint_req     = s_r.maint_req;
  assign maint_write   = s_r.maint_write;
  assign maint_addr    = s_r.maint_addr;
  assign maint_wdata   = s_r.maint_wdata;
  assign err_resp      = s_r.err_resp;
  assign resp_src_id   = s_r.resp_src;
  assign resp_dst_id   = s_r.resp_dst;
  assign resp_tid      = s_r.resp_tid;
endmodule : pprt_router

// file: pprt_router_assertions.sv
/* Port checker for pprt_router.
   Assumes it is bound to every pprt_router instance. */
`timescale 1ns/1ps
module pprt_router_chk
  import pprt_pkg::*;
#(
  parameter bit LARGE_SYSTEM = 1'b0  // Matches the router build
) (
  input wire logic             clock,           // Core clock
  input wire logic             rst_n,           // Async reset, active low
  input wire logic [NPORT-1:0] tx_tready,       // Port ready
  input wire logic             initiator_block, // Requests barred
  input wire logic             out_tvalid,      // Stream valid
  input wire logic             out_tready,      // Buffer accepts
  input wire logic [DATA_W-1:0] out_tdata,      // Stream data
  input wire logic [USER_W-1:0] out_tuser,      // Stream IDs
  input wire logic [15:0]      out_src_id,      // Source ID
  input wire logic [1:0]       id_size_code,    // Size code
  input wire logic             cfg_rd,          // Config read
  input wire logic             cfg_rvalid,      // Read valid
  input wire logic             rx_valid,        // Header valid
  input wire logic             rx_is_maint,     // Maint class
  input wire logic             rx_is_swrite,    // Streaming write
  input wire logic             rx_is_read,      // Read
  input wire logic             rx_needs_resp,   // Wants response
  input wire logic [7:0]       rx_size_m1,      // Size minus one
  input wire logic [15:0]      rx_src_id,       // Request source
  input wire logic [15:0]      rx_dst_id,       // Request dest
  input wire logic             io_req,          // To I/O
  input wire logic             maint_req,       // To maint port
  input wire logic             err_resp,        // Error response
  input wire logic [15:0]      resp_src_id,     // Response source
  input wire logic [15:0]      resp_dst_id      // Response dest
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_one; $onehot0(tx_tready); endproperty
  a_one: assert property (p_one) else $error("two ports ready");
  // Block sampled at packet start
  property p_blk;
    $rose(tx_tready[0]) || $rose(tx_tready[1]) |-> !$past(initiator_block) || !$past(initiator_block, 2);
  endproperty
  a_blk: assert property (p_blk) else $error("request port granted while blocked");
  property p_code; id_size_code == (LARGE_SYSTEM ? ID_SIZE_LARGE : ID_SIZE_SMALL); endproperty
  a_code: assert property (p_code) else $error("wrong id size code");
  property p_src; out_tvalid |-> out_src_id == out_tuser[31:16]; endproperty
  a_src: assert property (p_src) else $error("source id not from sideband");
  property p_swap; rx_valid |=> resp_src_id == $past(rx_dst_id) && resp_dst_id == $past(rx_src_id); endproperty
  a_swap: assert property (p_swap) else $error("response ids not swapped");
  property p_rd;
    rx_valid && rx_is_maint && rx_is_read && rx_size_m1 != SIZE_WORD_M1 |=> err_resp && !maint_req && !io_req;
  endproperty
  a_rd: assert property (p_rd) else $error("bad size read not refused");
  property p_wr;
    rx_valid && rx_is_maint && !rx_is_read && rx_size_m1 != SIZE_WORD_M1
      |=> !maint_req && !io_req && err_resp == $past(rx_needs_resp);
  endproperty
  a_wr: assert property (p_wr) else $error("bad size write not dropped");
  property p_sw; rx_valid && rx_is_swrite && !rx_is_maint |=> io_req && !maint_req; endproperty
  a_sw: assert property (p_sw) else $error("streaming write not to io");
  property p_hold; out_tvalid && !out_tready |=> out_tvalid && $stable(out_tdata); endproperty
  a_hold: assert property (p_hold) else $error("stream beat changed while stalled");
  property p_rv; cfg_rd |=> cfg_rvalid ##1 !cfg_rvalid || $past(cfg_rd); endproperty
  a_rv: assert property (p_rv) else $error("read valid timing");
  c_maint: cover property (maint_req);
  c_err: cover property (err_resp);
  c_stall: cover property (out_tvalid && !out_tready);
endmodule : pprt_router_chk

bind pprt_router pprt_router_chk #(.LARGE_SYSTEM(LARGE_SYSTEM)) pprt_router_chk_i (
  .clock(clock), .rst_n(rst_n), .tx_tready(tx_tready), .initiator_block(initiator_block),
  .out_tvalid(out_tvalid), .out_tready(out_tready), .out_tdata(out_tdata), .out_tuser(out_tuser),
  .out_src_id(out_src_id), .id_size_code(id_size_code), .cfg_rd(cfg_rd), .cfg_rvalid(cfg_rvalid),
  .rx_valid(rx_valid), .rx_is_maint(rx_is_maint), .rx_is_swrite(rx_is_swrite), .rx_is_read(rx_is_read),
  .rx_needs_resp(rx_needs_resp), .rx_size_m1(rx_size_m1), .rx_src_id(rx_src_id), .rx_dst_id(rx_dst_id),
  .io_req(io_req), .maint_req(maint_req), .err_resp(err_resp), .resp_src_id(resp_src_id),
  .resp_dst_id(resp_dst_id));

// file: pprt_buf_model.sv
/* Transmit buffer model on the router's stream output.
   Assumes the bench drives stall and reads the counters. */
`timescale 1ns/1ps
module pprt_buf_model #(
  parameter int WMARK = 4  // Fill level above which requests are barred
) (
  input  wire logic        clock,           // Core clock
  input  wire logic        rst_n,           // Async reset, active low
  input  wire logic        out_tvalid,      // Stream valid
  input  wire logic        out_tlast,       // Stream last
  input  wire logic [31:0] out_tuser,       // Stream IDs
  input  wire logic        host_grant_en,   // Requests allowed
  input  wire logic        stall,           // Bench asks for back-pressure
  output logic             out_tready,      // Accepts beat
  output logic             initiator_block, // Requests barred
  output logic [7:0]       pkt_cnt,         // Packets taken
  output logic [7:0]       beats            // Beats taken
);
  logic [7:0]  fill;
  logic [15:0] seen [0:15];
  assign initiator_block = !host_grant_en || (fill > 8'(WMARK));
  initial out_tready = 1'b0;
  always @(negedge clock) out_tready <= !stall;
  // Drains a beat a cycle unless stalled
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fill <= 8'h00; pkt_cnt <= 8'h00; beats <= 8'h00;
    end else begin
      fill <= fill + 8'(out_tvalid && out_tready) - 8'(fill != 8'h00 && !stall);
      if (out_tvalid && out_tready) beats <= beats + 8'h01;
      if (out_tvalid && out_tready && out_tlast) begin
        seen[pkt_cnt[3:0]] <= out_tuser[31:16];
        pkt_cnt <= pkt_cnt + 8'h01;
      end
    end
  end
endmodule : pprt_buf_model

// file: pprt_router_test.sv
/* Self-checking bench for pprt_router with a buffer model.
   Assumes default build parameters. */
`timescale 1ns/1ps
module pprt_router_test;
  import pprt_pkg::*;
  logic clock = 0, rst_n = 0, initiator_block, out_tready, stall = 0, cfg_wr = 0, cfg_rd = 0;
  logic [NPORT-1:0] tx_tvalid = '0, tx_tready, tx_tlast = '0, take = '0;
  logic [NPORT-1:0][DATA_W-1:0] tx_tdata = '0;
  logic [NPORT-1:0][USER_W-1:0] tx_tuser = '0;
  logic out_tvalid, out_tlast, host_grant_en, cfg_rvalid, io_req, maint_req, maint_write, err_resp;
  logic [DATA_W-1:0] out_tdata;
  logic [USER_W-1:0] out_tuser;
  logic [15:0] out_src_id, own_id, resp_src_id, resp_dst_id, rx_src_id = '0, rx_dst_id = '0;
  logic [1:0] id_size_code;
  logic [23:0] port_timeout, cfg_addr = '0, maint_addr;
  logic [31:0] cfg_wdata = '0, cfg_rdata, maint_wdata, rx_wdata = '0;
  logic rx_valid = 0, rx_is_maint = 0, rx_is_swrite = 0, rx_is_read = 0, rx_needs_resp = 0;
  logic [33:0] rx_addr = '0;
  logic [7:0] rx_size_m1 = '0, rx_tid = '0, pkt_cnt, beats;
  int errors = 0, total_checks = 0, n = 1;
  int pend [NPORT] = '{default: 0}, beat [NPORT] = '{default: 0};
  always #2 clock = ~clock;
  pprt_router pprt_router_i (.clock(clock), .rst_n(rst_n), .tx_tvalid(tx_tvalid), .tx_tready(tx_tready),
    .tx_tdata(tx_tdata), .tx_tlast(tx_tlast), .tx_tuser(tx_tuser), .initiator_block(initiator_block),
    .out_tvalid(out_tvalid), .out_tready(out_tready), .out_tdata(out_tdata), .out_tlast(out_tlast),
    .out_tuser(out_tuser), .out_src_id(out_src_id), .id_size_code(id_size_code), .own_id(own_id),
    .port_timeout(port_timeout), .host_grant_en(host_grant_en), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
    .rx_valid(rx_valid), .rx_is_maint(rx_is_maint), .rx_is_swrite(rx_is_swrite), .rx_is_read(rx_is_read),
    .rx_needs_resp(rx_needs_resp), .rx_addr(rx_addr), .rx_size_m1(rx_size_m1), .rx_src_id(rx_src_id),
    .rx_dst_id(rx_dst_id), .rx_tid(rx_tid), .rx_wdata(rx_wdata), .io_req(io_req), .maint_req(maint_req),
    .maint_write(maint_write), .maint_addr(maint_addr), .maint_wdata(maint_wdata), .err_resp(err_resp),
    .resp_src_id(resp_src_id), .resp_dst_id(resp_dst_id), .resp_tid());
  pprt_buf_model pprt_buf_model_i (.clock(clock), .rst_n(rst_n), .out_tvalid(out_tvalid),
    .out_tlast(out_tlast), .out_tuser(out_tuser), .host_grant_en(host_grant_en), .stall(stall),
    .out_tready(out_tready), .initiator_block(initiator_block), .pkt_cnt(pkt_cnt), .beats(beats));
  // Ports send two-beat packets
  always @(posedge clock) take <= tx_tvalid & tx_tready;
  always @(negedge clock) begin
    for (int i = 0; i < NPORT; i++) begin
      if (take[i]) begin
        if (beat[i] == 1) begin pend[i]--; beat[i] = 0; end else beat[i]++;
      end
      tx_tvalid[i] = pend[i] != 0;
      tx_tdata[i] = 64'(i * 16 + beat[i]);
      tx_tlast[i] = beat[i] == 1;
      tx_tuser[i] = {16'h0100 + 16'(i), 16'h0000};
    end
  end
  task end_of_test;
    if (errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  task chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin errors++; $display("mismatch at %0t: %s", $time, m); end
  endtask : chk
  task cfg_w(input logic [23:0] a, input logic [31:0] d);
    @(negedge clock); cfg_wr = 1; cfg_addr = a; cfg_wdata = d;
    @(negedge clock); cfg_wr = 0;
  endtask : cfg_w
  task cfg_r(input logic [23:0] a, input logic [31:0] e);
    @(negedge clock); cfg_rd = 1; cfg_addr = a;
    @(negedge clock); cfg_rd = 0;
    chk(cfg_rvalid, 1, "read valid");
    chk(cfg_rdata, e, "read data");
  endtask : cfg_r
  task rx(input logic mt, sw, rd, nr, input logic [33:0] a, input logic [7:0] s, input logic [2:0] e);
    @(negedge clock); rx_valid = 1; rx_is_maint = mt; rx_is_swrite = sw; rx_is_read = rd;
    rx_needs_resp = nr; rx_addr = a; rx_size_m1 = s; rx_src_id = 16'(n); rx_dst_id = 16'(n + 256);
    @(negedge clock); rx_valid = 0;
    chk({io_req, maint_req, err_resp}, e, "steering");
    chk({resp_src_id, resp_dst_id}, {16'(n + 256), 16'(n)}, "response ids");
    if (e[1]) chk({maint_write, maint_addr}, {!rd, a[23:0]}, "maint fields");
    n++;
  endtask : rx
  task t_reset;
    chk(id_size_code, ID_SIZE_SMALL, "size code");
    chk(port_timeout, 24'hffffff, "timeout reset");
    chk(host_grant_en, 0, "host grant reset");
    cfg_r(OFF_WIN_BASE, 32'h7fe0_0000);
    cfg_r(24'h000010, 32'h0000_0000);
  endtask : t_reset
  task t_regs;
    cfg_w(OFF_BASE_ID, 32'h00ab_1234);
    cfg_r(OFF_BASE_ID, 32'h00ab_1234);
    chk(own_id, 16'h00ab, "own id");
    cfg_w(OFF_RESP_TIMEOUT, 32'h1234_5600);
    cfg_r(OFF_RESP_TIMEOUT, 32'h1234_5600);
    chk(port_timeout, 24'h123456, "timeout");
  endtask : t_regs
  task t_rx;
    rx(0, 0, 1, 0, 34'h3_ff00_0000, 8'h03, 3'b010);
    rx(0, 0, 1, 0, 34'h3_feff_fffc, 8'h03, 3'b100);
    rx(0, 1, 0, 0, 34'h3_ff00_0000, 8'h07, 3'b100);
    rx(0, 0, 1, 0, 34'h3_ff00_0010, 8'h07, 3'b001);
    rx(0, 0, 0, 1, 34'h3_ff00_0020, 8'h01, 3'b001);
    rx(0, 0, 0, 0, 34'h3_ff00_0020, 8'h00, 3'b000);
    rx(1, 0, 0, 0, 34'h0_0000_0060, 8'h03, 3'b010);
    cfg_w(OFF_WIN_BASE, 32'h0020_0000);
    rx(0, 0, 1, 0, 34'h0_0100_0000, 8'h03, 3'b010);
    rx(0, 0, 1, 0, 34'h3_ff00_0000, 8'h03, 3'b100);
  endtask : t_rx
  task t_tx;
    @(posedge clock); pend[0] = 1; pend[2] = 1;
    repeat (30) @(negedge clock);
    chk(pkt_cnt, 1, "blocked count");
    chk(pprt_buf_model_i.seen[0], 16'h0102, "response first");
    chk(tx_tvalid[0], 1, "request held");
    cfg_w(OFF_PORT_GEN_CTL, 32'h4000_0000);
    repeat (20) @(negedge clock);
    chk(host_grant_en, 1, "host grant");
    chk(pprt_buf_model_i.seen[1], 16'h0100, "request after block");
    // Order now 1, 2, 0; stall fills the router's two-entry buffer
    @(posedge clock); pend = '{1, 1, 1}; stall = 1;
    repeat (12) @(negedge clock);
    stall = 0;
    repeat (40) @(negedge clock);
    chk(pkt_cnt, 5, "packet count");
    chk(beats, 10, "beat count");
    chk(pprt_buf_model_i.seen[2], 16'h0101, "lru first");
    chk(pprt_buf_model_i.seen[3], 16'h0102, "lru second");
    chk(pprt_buf_model_i.seen[4], 16'h0100, "lru third");
  endtask : t_tx
  initial begin
    repeat (5) @(negedge clock);
    rst_n = 1;
    t_reset;
    t_regs;
    t_rx;
    t_tx;
    end_of_test;
  end
  initial begin
    #20000;
    errors++;
    end_of_test;
  end
endmodule : pprt_router_test
